/* File: pfp_pkg.sv */
// Constants and carrier types for the pin fault protection block
package pfp_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int FIRST_LIMIT_LONG_NS = 2000;
  localparam int FIRST_LIMIT_SHORT_NS = 1000;
  localparam int BIAS_SAMPLE_DELAY_NS = 10000;
  localparam int FAULT_RECOVERY_DELAY_MS = 1500;
  // Longest times round down, least times round up
  localparam int FIRST_LIMIT_LONG_CYC = FIRST_LIMIT_LONG_NS / CLK_PERIOD_NS;
  localparam int FIRST_LIMIT_SHORT_CYC = FIRST_LIMIT_SHORT_NS / CLK_PERIOD_NS;
  localparam int BIAS_SAMPLE_CYC = (BIAS_SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAULT_RECOVERY_CYC = FAULT_RECOVERY_DELAY_MS * (1000000 / CLK_PERIOD_NS);
  localparam int FAULT_PULSE_COUNT = 3;
  localparam int PULSE_CNT_W = 8;
  localparam int RECOVERY_CNT_W = 24;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_RUN, ST_LOCKOUT, ST_RECOVER} pfp_state_t;

  // Analog comparator results arriving from the pins
  typedef struct packed {
    logic supplyAtOn;
    logic supplyAtOff;
    logic fetTypeSilicon;
    logic demagResHigh;
    logic csOverOcp;
    logic biasBelowOpen;
    logic biasOverVolt;
    logic demagPinOpen;
    logic demagPinShort;
    logic zvsPinOpen;
    logic zvsPinShort;
  } pfp_pins_t;

  typedef struct packed {
    logic csShort;
    logic csOpen;
    logic biasOpen;
    logic biasOverVolt;
    logic progPin;
  } pfp_faults_t;
endpackage : pfp_pkg

/* File: pfp_pin_fault_protection.sv */
// Pin open/short fault detection and response sequencer
// Function
// - Silicon select: cut first pulse at limit, flag sense short, start recovery delay
// - Wide-bandgap select: first limit 2 us if demag resistor high, else 1 us
// - Sense short checked on first pulse only; sense open every cycle
// - Three consecutive over-threshold sense pulses: open fault, stop, recovery delay
// - Let bias regulator settle after supply turn-on before gate switches
// - 10 us after turn-on sample bias pin; below 14 V means lockout cycle
// - Bias over-voltage on three consecutive pulses triggers one lockout cycle
// - At start-up apply test voltage to program pins; any open or short sets the one progPin flag
// - Program pin fault: no switching, one lockout cycle, retry next cycle
// - During recovery only cycle supply; restart at turn-off after delay expires
module pfp_pin_fault_protection #(
  parameter int RECOVERY_CYCLES = pfp_pkg::FAULT_RECOVERY_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire pfp_pkg::pfp_pins_t pinsAsync,
  input wire logic gateRequest,
  output logic lowSideGateDrive,
  output logic progPinTestEn,
  output logic lockoutRequest,
  output logic recoveryActive,
  output pfp_pkg::pfp_faults_t faultFlags
);
  // Delay counter must hold the whole recovery span
  if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES >= (1 << pfp_pkg::RECOVERY_CNT_W))
  begin : g_bad_recovery
    $error("RECOVERY_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  pfp_pkg::pfp_pins_t syncA_q;
  pfp_pkg::pfp_pins_t pins_q;
  logic onPrev_q;
  logic offPrev_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      syncA_q <= '0;
      pins_q <= '0;
      onPrev_q <= 1'b0;
      offPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      syncA_q <= pinsAsync;
      pins_q <= syncA_q;
      onPrev_q <= pins_q.supplyAtOn;
      offPrev_q <= pins_q.supplyAtOff;
    end
  end

  wire logic onRise = pins_q.supplyAtOn & ~onPrev_q;
  wire logic offRise = pins_q.supplyAtOff & ~offPrev_q;

  // ------------------------------------------------------------
  // State and counters
  // ------------------------------------------------------------
  pfp_pkg::pfp_state_t state_q, state_d;
  logic [pfp_pkg::PULSE_CNT_W-1:0] timer_q;
  logic [pfp_pkg::RECOVERY_CNT_W-1:0] recCnt_q;
  logic firstPulse_q;
  logic [1:0] csCnt_q;
  logic [1:0] ovCnt_q;
  logic csSeen_q;
  logic ovSeen_q;
  logic gate_q;
  logic progTest_q;
  logic lockout_q;
  logic recovering_q;
  pfp_pkg::pfp_faults_t faults_q;

  // First pulse limit selection
  wire logic longLimit = pins_q.fetTypeSilicon | pins_q.demagResHigh;
  wire logic [pfp_pkg::PULSE_CNT_W-1:0] firstLimit = longLimit ?
    pfp_pkg::PULSE_CNT_W'(pfp_pkg::FIRST_LIMIT_LONG_CYC) :
    pfp_pkg::PULSE_CNT_W'(pfp_pkg::FIRST_LIMIT_SHORT_CYC);
  wire logic limitHit = firstPulse_q & gate_q & (timer_q == firstLimit - 8'h01);

  // Start-up checks
  wire logic sampleNow = (state_q == pfp_pkg::ST_SETTLE) &
    (timer_q == pfp_pkg::PULSE_CNT_W'(pfp_pkg::BIAS_SAMPLE_CYC - 1));
  wire logic progFault = pins_q.demagPinOpen | pins_q.demagPinShort |
    pins_q.zvsPinOpen | pins_q.zvsPinShort;
  wire logic biasOpenHit = sampleNow & pins_q.biasBelowOpen;
  wire logic progHit = sampleNow & progFault;

  // Cycle-by-cycle qualification at pulse end
  wire logic gateNext = (state_q == pfp_pkg::ST_RUN) & gateRequest & ~limitHit;
  wire logic pulseEnd = gate_q & ~gateNext;
  wire logic csThis = csSeen_q | pins_q.csOverOcp;
  wire logic ovThis = ovSeen_q | pins_q.biasOverVolt;
  wire logic [1:0] lastCount = 2'(pfp_pkg::FAULT_PULSE_COUNT - 1);
  wire logic csOpenHit = pulseEnd & csThis & (csCnt_q == lastCount);
  wire logic ovHit = pulseEnd & ovThis & (ovCnt_q == lastCount);
  wire logic recDone = (recCnt_q == pfp_pkg::RECOVERY_CNT_W'(RECOVERY_CYCLES - 1));

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      pfp_pkg::ST_IDLE:
        if (onRise)
          state_d = pfp_pkg::ST_SETTLE;
      pfp_pkg::ST_SETTLE:
        if (biasOpenHit || progHit)
          state_d = pfp_pkg::ST_LOCKOUT;
        else if (sampleNow)
          state_d = pfp_pkg::ST_RUN;
      pfp_pkg::ST_RUN:
        if (limitHit || csOpenHit)
          state_d = pfp_pkg::ST_RECOVER;
        else if (ovHit || offRise)
          state_d = pfp_pkg::ST_LOCKOUT;
      pfp_pkg::ST_LOCKOUT:
        if (offRise)
          state_d = pfp_pkg::ST_IDLE;
      pfp_pkg::ST_RECOVER:
        if (recovering_q == 1'b0 && offRise)
          state_d = pfp_pkg::ST_IDLE;
      default:
        state_d = pfp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_q <= pfp_pkg::ST_IDLE;
    else if (clkEn)
      state_q <= state_d;
  end

  // Shared timer: settle delay, then gate on-time
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      timer_q <= '0;
    else if (clkEn)
      timer_q <= (state_q != state_d || !gate_q && state_q == pfp_pkg::ST_RUN) ? '0 :
        timer_q + 8'h01;
  end

  // Recovery delay runs regardless of supply cycling
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      recCnt_q <= '0;
      recovering_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (state_q == pfp_pkg::ST_RUN && state_d == pfp_pkg::ST_RECOVER)
      begin
        recCnt_q <= '0;
        recovering_q <= 1'b1;
      end
      else if (recovering_q)
      begin
        recCnt_q <= recCnt_q + 24'h000001;
        recovering_q <= ~recDone;
      end
    end
  end

  // Gate and per-pulse fault qualification
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      gate_q <= 1'b0;
      firstPulse_q <= 1'b0;
      csSeen_q <= 1'b0;
      ovSeen_q <= 1'b0;
      csCnt_q <= '0;
      ovCnt_q <= '0;
    end
    else if (clkEn)
    begin
      gate_q <= gateNext;
      if (state_q == pfp_pkg::ST_SETTLE)
        firstPulse_q <= 1'b1;
      else if (pulseEnd)
        firstPulse_q <= 1'b0;
      csSeen_q <= gateNext & csThis & gate_q;
      ovSeen_q <= gateNext & ovThis & gate_q;
      if (state_q != pfp_pkg::ST_RUN)
      begin
        csCnt_q <= '0;
        ovCnt_q <= '0;
      end
      else if (pulseEnd)
      begin
        csCnt_q <= csThis ? csCnt_q + 2'h1 : 2'h0;
        ovCnt_q <= ovThis ? ovCnt_q + 2'h1 : 2'h0;
      end
    end
  end

  // Fault flags hold until the next start-up
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      faults_q <= '0;
      progTest_q <= 1'b0;
      lockout_q <= 1'b0;
    end
    else if (clkEn)
    begin
      if (onRise && state_q == pfp_pkg::ST_IDLE)
        faults_q <= '0;
      else
      begin
        faults_q.csShort <= faults_q.csShort | limitHit;
        faults_q.csOpen <= faults_q.csOpen | (csOpenHit & ~limitHit);
        faults_q.biasOpen <= faults_q.biasOpen | biasOpenHit;
        faults_q.biasOverVolt <= faults_q.biasOverVolt | (ovHit & ~limitHit & ~csOpenHit);
        faults_q.progPin <= faults_q.progPin | progHit;
      end
      progTest_q <= (state_d == pfp_pkg::ST_SETTLE);
      lockout_q <= (state_d == pfp_pkg::ST_LOCKOUT) || (state_d == pfp_pkg::ST_RECOVER);
    end
  end

  assign lowSideGateDrive = gate_q;
  assign progPinTestEn = progTest_q;
  assign lockoutRequest = lockout_q;
  assign recoveryActive = recovering_q;
  assign faultFlags = faults_q;

  // On-time seen at the gate output, kept apart from the shared timer
  logic [pfp_pkg::PULSE_CNT_W-1:0] onTime_q;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      onTime_q <= '0;
    else if (clkEn)
      onTime_q <= gate_q ? onTime_q + 8'h01 : '0;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_first_limit_long: assert property (lowSideGateDrive && firstPulse_q && longLimit |->
    onTime_q < 8'(pfp_pkg::FIRST_LIMIT_LONG_CYC)) else $error("long limit wrong");
  a_first_limit_short: assert property (lowSideGateDrive && firstPulse_q && !longLimit |->
    onTime_q < 8'(pfp_pkg::FIRST_LIMIT_SHORT_CYC)) else $error("short limit wrong");
  a_short_first_only: assert property (clkEn && !firstPulse_q && !faultFlags.csShort |=>
    !faultFlags.csShort) else $error("short check past first pulse");
  a_open_stops_gate: assert property (clkEn && csOpenHit |=>
    !lowSideGateDrive && recoveryActive && faultFlags.csOpen) else $error("open fault ignored");
  a_no_gate_settle: assert property (state_q == pfp_pkg::ST_SETTLE |=>
    !lowSideGateDrive) else $error("gate during settle");
  a_bias_open_lock: assert property (clkEn && biasOpenHit |=>
    lockoutRequest && faultFlags.biasOpen) else $error("bias open missed");
  a_ov_lockout: assert property (clkEn && ovHit && !limitHit && !csOpenHit |=>
    lockoutRequest && !lowSideGateDrive) else $error("bias overvoltage missed");
  a_test_in_settle: assert property (progPinTestEn |->
    state_q == pfp_pkg::ST_SETTLE) else $error("test voltage outside start-up");
  a_prog_no_switch: assert property (clkEn && progHit |=>
    !lowSideGateDrive [*8]) else $error("switching after program fault");
  a_recover_quiet: assert property (state_q == pfp_pkg::ST_RECOVER |->
    !lowSideGateDrive) else $error("gate pulse during recovery");
  a_counter_clear: assert property (clkEn && pulseEnd && !csThis &&
    state_q == pfp_pkg::ST_RUN |=> csCnt_q == 2'h0) else $error("counter not cleared");
endmodule : pfp_pin_fault_protection

/* File: pfp_power_stage.sv */
// Far-side model: power stage, sense parts and program resistors
module pfp_power_stage (
  input wire logic progPinTestEn,
  input wire logic supplyOn,
  input wire logic supplyOff,
  input wire logic silicon,
  input wire logic demagHigh,
  input wire logic csOpenFault,
  input wire logic biasOpenFault,
  input wire logic biasOvFault,
  input wire logic [3:0] progFault,
  output pfp_pkg::pfp_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Comparator levels
  // ----------------------------------------
  // Open sense pin floats high, so it reads over threshold at all times
  // Open bias pin falls to 13 V at once, so it reads low at the sample
  // Program pin current exists only while the test voltage is applied
  assign pins = {supplyOn, supplyOff, silicon, demagHigh, csOpenFault, biasOpenFault,
    biasOvFault, progFault & {4{progPinTestEn}}};
endmodule : pfp_power_stage

/* File: pfp_pin_fault_protection_tb.sv */
// Self-checking testbench for the pin fault protection block
module pfp_pin_fault_protection_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Short recovery delay keeps the run brief
  localparam int RCYC = 50;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic gateRequest = 1'b0;
  logic supplyOn = 1'b0;
  logic supplyOff = 1'b0;
  logic silicon = 1'b1;
  logic demagHigh = 1'b1;
  logic csOpenFault = 1'b0;
  logic biasOpenFault = 1'b0;
  logic biasOvFault = 1'b0;
  logic [3:0] progFault = 4'h0;
  logic gate;
  logic testEn;
  logic lockout;
  logic recovery;
  pfp_pkg::pfp_pins_t pins;
  pfp_pkg::pfp_faults_t faultFlags;
  int n_errors = 0;
  int checked = 0;

  pfp_power_stage i_stage (.progPinTestEn(testEn), .supplyOn(supplyOn), .supplyOff(supplyOff),
    .silicon(silicon), .demagHigh(demagHigh), .csOpenFault(csOpenFault),
    .biasOpenFault(biasOpenFault), .biasOvFault(biasOvFault), .progFault(progFault),
    .pins(pins));
  pfp_pin_fault_protection #(.RECOVERY_CYCLES(RCYC)) i_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clkEn(1'b1), .pinsAsync(pins), .gateRequest(gateRequest),
    .lowSideGateDrive(gate), .progPinTestEn(testEn), .lockoutRequest(lockout),
    .recoveryActive(recovery), .faultFlags(faultFlags));

  initial forever #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    checked++;
    if (seen !== expv)
    begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Flags, then {lockout, recovery}
  task automatic state(input logic [4:0] flags, input logic [1:0] lr);
    check(8'(faultFlags), 8'(flags));
    check(8'({lockout, recovery}), 8'(lr));
  endtask : state

  // Negative expHi skips the width compare
  task automatic pulse(input int len, input int expHi);
    int n;
    n = 0;
    repeat (4) @(posedge sys_clk);
    gateRequest <= 1'b1;
    for (int i = 0; i < len + 4; i++)
    begin
      @(negedge sys_clk);
      if (gate === 1'b1)
        n++;
      if (i == len - 1)
        @(posedge sys_clk) gateRequest <= 1'b0;
    end
    if (expHi >= 0)
      check(8'(n), 8'(expHi));
  endtask : pulse

  task automatic start(input logic doReset);
    int n;
    n = 0;
    if (doReset)
    begin
      @(posedge sys_clk) sys_rst <= 1'b1;
      supplyOn <= 1'b0;
      repeat (4) @(negedge sys_clk);
      state(5'h00, 2'b00);
      check(8'({gate, testEn}), 8'h00);
      @(posedge sys_clk) sys_rst <= 1'b0;
    end
    @(posedge sys_clk) supplyOn <= 1'b1;
    for (int i = 0; i < 220 && !(n > 0 && testEn === 1'b0); i++)
    begin
      @(negedge sys_clk);
      if (testEn === 1'b1)
        n++;
    end
    check(8'(n >= pfp_pkg::BIAS_SAMPLE_CYC && n <= pfp_pkg::BIAS_SAMPLE_CYC + 2), 8'h01);
  endtask : start

  task automatic supplyCycle;
    @(posedge sys_clk) supplyOn <= 1'b0;
    supplyOff <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check(8'(lockout), 8'h00);
    @(posedge sys_clk) supplyOff <= 1'b0;
  endtask : supplyCycle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_first_pulse;
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk) silicon <= (k == 0);
      demagHigh <= (k == 1);
      start(1'b1);
      pulse(30, k == 2 ? pfp_pkg::FIRST_LIMIT_SHORT_CYC : pfp_pkg::FIRST_LIMIT_LONG_CYC);
      state(5'h10, 2'b11);
      pulse(6, 0);
      // Turn-off while the delay counts must not end it
      @(posedge sys_clk) supplyOff <= 1'b1;
      repeat (4) @(posedge sys_clk);
      supplyOff <= 1'b0;
      @(negedge sys_clk);
      state(5'h10, 2'b11);
      for (int i = 0; i < RCYC + 10 && recovery !== 1'b0; i++)
        @(negedge sys_clk);
      state(5'h10, 2'b10);
      supplyCycle();
    end
    start(1'b0);
    state(5'h00, 2'b00);
  endtask : t_first_pulse

  task automatic t_later_pulses;
    start(1'b1);
    pulse(5, 5);
    pulse(30, 30);
    state(5'h00, 2'b00);
  endtask : t_later_pulses

  task automatic t_cs_open;
    start(1'b1);
    @(posedge sys_clk) csOpenFault <= 1'b1;
    pulse(6, 6);
    pulse(6, 6);
    @(posedge sys_clk) csOpenFault <= 1'b0;
    pulse(6, 6);
    @(posedge sys_clk) csOpenFault <= 1'b1;
    pulse(6, 6);
    pulse(6, 6);
    state(5'h00, 2'b00);
    pulse(6, -1);
    state(5'h08, 2'b11);
    pulse(6, 0);
    @(posedge sys_clk) csOpenFault <= 1'b0;
  endtask : t_cs_open

  task automatic t_bias_ov;
    start(1'b1);
    @(posedge sys_clk) biasOvFault <= 1'b1;
    pulse(6, 6);
    pulse(6, 6);
    state(5'h00, 2'b00);
    pulse(6, -1);
    state(5'h02, 2'b10);
    @(posedge sys_clk) biasOvFault <= 1'b0;
  endtask : t_bias_ov

  task automatic t_bias_open;
    @(posedge sys_clk) biasOpenFault <= 1'b1;
    start(1'b1);
    state(5'h04, 2'b10);
    pulse(6, 0);
    @(posedge sys_clk) biasOpenFault <= 1'b0;
  endtask : t_bias_open

  task automatic t_prog;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk) progFault <= 4'h1 << k;
      start(1'b1);
      state(5'h01, 2'b10);
      pulse(6, 0);
      @(posedge sys_clk) progFault <= 4'h0;
      supplyCycle();
      start(1'b0);
      state(5'h00, 2'b00);
      pulse(6, 6);
    end
  endtask : t_prog

  initial
  begin
    repeat (16) @(posedge sys_clk);
    t_first_pulse();
    t_later_pulses();
    t_cs_open();
    t_bias_ov();
    t_bias_open();
    t_prog();
    report_and_stop();
  end

  // Whole run needs about 2400 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end
endmodule : pfp_pin_fault_protection_tb
